// ==== rwwsp_self_program_control.v ====
// Read-while-write self-programming control with AHB-Lite register slave
`timescale 1ns/1ps
`include "rwwsp_defs.vh"

// Operation
// - Store-program-memory ops fetched from the application section are ignored.
// - From the boot loader section any flash page may be targeted.
// - Section split comes from boot size fuses; each section has own protection.
// - Flash also splits at a fixed boundary into read-while-write and other region.
// - Stall or concurrency is chosen from the target page address, not fetch address.
// - Target in read-while-write region: CPU runs, fetches from other region.
// - Target in no-read-while-write region: CPU stalled for the whole operation.
// - Boot loader section always lies inside the no-read-while-write region.
// - Busy flag reads one while the read-while-write region is blocked.
// - Busy flag stays set after programming until software clears it.
// - Two independent boot lock sets: application and boot loader section.
// - Lock bits can be programmed by software; only chip erase or reset restores them.
// - Target address is Z pointer extended by the page high pointer register.
module rwwsp_self_program_control #(
    parameter integer PROG_CYCLES = `RWWSP_PROG_CYCLES,
    parameter [23:0] FLASH_BYTES = `RWWSP_FLASH_BYTES,
    parameter [23:0] NO_READ_WHILE_WRITE_REGION_START = `RWWSP_NO_READ_WHILE_WRITE_REGION_START,
    parameter [23:0] BOOT_BASE_BYTES = `RWWSP_BOOT_BASE_BYTES
) (
    input wire sys_clk_in,                  // System clock, 250 MHz
    input wire reset_n_in,                  // Synchronous reset, active low
    input wire hsel_in,                     // AHB slave select
    input wire [31:0] haddr_in,             // AHB address
    input wire [1:0] htrans_in,             // AHB transfer type
    input wire hwrite_in,                   // AHB write
    input wire [2:0] hsize_in,              // AHB size
    input wire [31:0] hwdata_in,            // AHB write data
    input wire hready_in,                   // AHB bus ready
    output reg [31:0] hrdata_out,           // AHB read data
    output wire hreadyout_out,              // AHB slave ready
    output wire hresp_out,                  // AHB response, always OKAY
    input wire store_program_memory_op_in,  // CPU issues a store-program-memory op
    input wire [1:0] op_code_in,            // Operation code of that op
    input wire [23:0] op_fetch_addr_in,     // Byte address the op was fetched from
    input wire [15:0] z_pointer_in,         // Z pointer register pair
    input wire [1:0] boot_size_fuses_in,    // Boot size fuses, asynchronous
    input wire chip_erase_in,               // Chip erase pulse from programming port
    input wire [3:0] lock_program_in,       // Lock bits to program (zeros program)
    input wire lock_program_we_in,          // Strobe for lock_program_in
    output wire cpu_stall_out,              // CPU stall request
    output wire rww_fetch_block_out,        // Block fetches from the rww region
    output wire rww_region_busy_flag_out,   // Busy flag for the rww region
    output wire [23:0] boot_start_out,      // First byte of boot loader section
    output wire flash_prog_busy_out,        // Page erase or write running
    output wire irq_out                     // Level interrupt
);
    localparam ST_IDLE = 1'b0;
    localparam ST_PROG = 1'b1;

    reg state_reg;
    reg state_next;
    reg [1:0] fuse_meta_reg;
    reg [1:0] fuse_sync_reg;
    reg [7:0] program_page_high_pointer_reg;
    reg [3:0] lock_reg;
    reg rww_flag_reg;
    reg target_no_read_while_write_region_reg;
    reg [23:0] last_target_reg;
    reg [`RWWSP_EV_W-1:0] irq_status_reg;
    reg [`RWWSP_EV_W-1:0] irq_mask_reg;
    reg [`RWWSP_EV_W-1:0] event_next;
    reg wr_pending_reg;
    reg [7:0] wr_addr_reg;

    wire timer_busy;
    wire timer_done;
    wire [23:0] target_addr;
    wire [23:0] boot_size;
    wire [23:0] boot_start_raw;
    wire [23:0] boot_start;
    wire fetch_in_boot;
    wire target_in_boot;
    wire target_in_no_read_while_write_region;
    wire write_protected;
    wire is_page_op;
    wire op_ok;
    wire start_prog;
    wire rww_enable_op;
    wire ahb_take;
    wire [7:0] ahb_ofs;
    wire wr_cs;
    wire wr_ph;
    wire wr_lock;
    wire wr_irq_st;
    wire wr_irq_mask;
    reg [31:0] rd_next;

    // Fuse pins are static straps but arrive unsynchronised
    always @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            fuse_meta_reg <= 2'h3;
            fuse_sync_reg <= 2'h3;
        end else begin
            fuse_meta_reg <= boot_size_fuses_in;
            fuse_sync_reg <= fuse_meta_reg;
        end
    end

    // Smallest boot section when all fuses are unprogrammed
    assign boot_size = BOOT_BASE_BYTES << (~fuse_sync_reg);
    assign boot_start_raw = FLASH_BYTES - boot_size;
    // Clamp keeps the boot section inside the stall region for any fuse choice
    assign boot_start = (boot_start_raw < NO_READ_WHILE_WRITE_REGION_START) ? NO_READ_WHILE_WRITE_REGION_START : boot_start_raw;
    assign boot_start_out = boot_start;

    assign target_addr = {program_page_high_pointer_reg, z_pointer_in};
    assign fetch_in_boot = (op_fetch_addr_in >= boot_start);
    assign target_in_boot = (target_addr >= boot_start);
    assign target_in_no_read_while_write_region = (target_addr >= NO_READ_WHILE_WRITE_REGION_START);

    // Write protection when the low bit of the section's lock pair is programmed
    assign write_protected = target_in_boot ?
        ~lock_reg[`RWWSP_LOCK_BOOT_LO] :
        ~lock_reg[`RWWSP_LOCK_APP_LO];

    assign is_page_op = (op_code_in == `RWWSP_OP_ERASE) ||
        (op_code_in == `RWWSP_OP_WRITE);
    // Fetch location and an idle state gate acceptance; any target is legal from boot
    assign op_ok = store_program_memory_op_in && fetch_in_boot && (state_reg == ST_IDLE);
    assign start_prog = op_ok && is_page_op && !write_protected;
    assign rww_enable_op = op_ok && (op_code_in == `RWWSP_OP_RWW_ENABLE);

    rwwsp_prog_timer #(
        .CYCLES(PROG_CYCLES),
        .CNT_W(24)
    ) u_timer (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .start_in(start_prog),
        .busy_out(timer_busy),
        .done_out(timer_done)
    );

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_prog) begin
                    state_next = ST_PROG;
                end
            end
            ST_PROG: begin
                if (timer_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            state_reg <= ST_IDLE;
            target_no_read_while_write_region_reg <= 1'b0;
            last_target_reg <= 24'h000000;
        end else begin
            state_reg <= state_next;
            if (start_prog) begin
                target_no_read_while_write_region_reg <= target_in_no_read_while_write_region;
                last_target_reg <= target_addr;
            end
        end
    end

    assign flash_prog_busy_out = (state_reg == ST_PROG) && timer_busy;
    // Whole operation stalls the core when the page is in the stall region
    // Follows the timer, not the state, so the stall ends with the operation
    assign cpu_stall_out = flash_prog_busy_out && target_no_read_while_write_region_reg;
    // Other region stays readable; only the rww region is fenced off
    assign rww_fetch_block_out = rww_flag_reg;
    assign rww_region_busy_flag_out = rww_flag_reg;

    // AHB-Lite slave: zero wait states, writes land in the data phase
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign ahb_take = hsel_in && htrans_in[1] && hready_in;
    assign ahb_ofs = {haddr_in[7:2], 2'b00};

    always @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            wr_pending_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pending_reg <= ahb_take && hwrite_in;
            if (ahb_take) begin
                wr_addr_reg <= ahb_ofs;
            end
        end
    end

    assign wr_cs = wr_pending_reg && (wr_addr_reg == `RWWSP_OFS_CTRL_STATUS);
    assign wr_ph = wr_pending_reg && (wr_addr_reg == `RWWSP_OFS_PAGE_HIGH);
    assign wr_lock = wr_pending_reg && (wr_addr_reg == `RWWSP_OFS_LOCK);
    assign wr_irq_st = wr_pending_reg && (wr_addr_reg == `RWWSP_OFS_IRQ_STATUS);
    assign wr_irq_mask = wr_pending_reg && (wr_addr_reg == `RWWSP_OFS_IRQ_MASK);

    always @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            program_page_high_pointer_reg <= 8'h00;
            irq_mask_reg <= {`RWWSP_EV_W{1'b0}};
        end else begin
            if (wr_ph) begin
                program_page_high_pointer_reg <= hwdata_in[7:0];
            end
            if (wr_irq_mask) begin
                irq_mask_reg <= hwdata_in[`RWWSP_EV_W-1:0];
            end
        end
    end

    // Lock bits only move toward programmed; only chip erase or reset restores them
    always @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            lock_reg <= `RWWSP_LOCK_RESET;
        end else if (chip_erase_in) begin
            lock_reg <= `RWWSP_LOCK_RESET;
        end else begin
            if (wr_lock && lock_program_we_in) begin
                lock_reg <= lock_reg & hwdata_in[3:0] & lock_program_in;
            end else if (wr_lock) begin
                lock_reg <= lock_reg & hwdata_in[3:0];
            end else if (lock_program_we_in) begin
                lock_reg <= lock_reg & lock_program_in;
            end
        end
    end

    // Flag set when an rww page operation starts; clearing is refused while busy
    always @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            rww_flag_reg <= 1'b0;
        end else if (start_prog && !target_in_no_read_while_write_region) begin
            rww_flag_reg <= 1'b1;
        end else if ((state_reg == ST_IDLE) &&
                     ((wr_cs && hwdata_in[`RWWSP_CS_RWW_CLEAR]) || rww_enable_op)) begin
            rww_flag_reg <= 1'b0;
        end
    end

    always @* begin
        event_next = {`RWWSP_EV_W{1'b0}};
        event_next[`RWWSP_EV_DONE] = timer_done;
        event_next[`RWWSP_EV_REJECT] = store_program_memory_op_in && !fetch_in_boot;
        event_next[`RWWSP_EV_LOCKED] = op_ok && is_page_op && write_protected;
    end

    // New events win over a write-one-to-clear in the same cycle
    always @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            irq_status_reg <= {`RWWSP_EV_W{1'b0}};
        end else if (wr_irq_st) begin
            irq_status_reg <= (irq_status_reg & ~hwdata_in[`RWWSP_EV_W-1:0]) | event_next;
        end else begin
            irq_status_reg <= irq_status_reg | event_next;
        end
    end

    assign irq_out = |(irq_status_reg & irq_mask_reg);

    always @* begin
        rd_next = 32'h00000000;
        case (ahb_ofs)
            `RWWSP_OFS_CTRL_STATUS: begin
                rd_next[`RWWSP_CS_BUSY] = (state_reg == ST_PROG);
                rd_next[`RWWSP_CS_RWW_FLAG] = rww_flag_reg;
                rd_next[`RWWSP_CS_STALL] = cpu_stall_out;
            end
            `RWWSP_OFS_PAGE_HIGH: begin
                rd_next[7:0] = program_page_high_pointer_reg;
            end
            `RWWSP_OFS_LOCK: begin
                rd_next[3:0] = lock_reg;
            end
            `RWWSP_OFS_IRQ_STATUS: begin
                rd_next[`RWWSP_EV_W-1:0] = irq_status_reg;
            end
            `RWWSP_OFS_IRQ_MASK: begin
                rd_next[`RWWSP_EV_W-1:0] = irq_mask_reg;
            end
            `RWWSP_OFS_LAST_TARGET: begin
                rd_next[23:0] = last_target_reg;
            end
            default: begin
                rd_next = 32'h00000000;
            end
        endcase
    end

    // Read data is captured in the address phase, so a read right after a
    // write to the same register returns the value before that write
    always @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            hrdata_out <= 32'h00000000;
        end else if (ahb_take && !hwrite_in) begin
            hrdata_out <= rd_next;
        end
    end
endmodule

// ==== rwwsp_defs.vh ====
// Offsets, field positions, reset values and timing counts of the self-programming control
`ifndef RWWSP_DEFS_VH
`define RWWSP_DEFS_VH

// Register byte offsets
`define RWWSP_OFS_CTRL_STATUS 8'h00
`define RWWSP_OFS_PAGE_HIGH 8'h04
`define RWWSP_OFS_LOCK 8'h08
`define RWWSP_OFS_IRQ_STATUS 8'h0C
`define RWWSP_OFS_IRQ_MASK 8'h10
`define RWWSP_OFS_LAST_TARGET 8'h14

// Control/status fields
`define RWWSP_CS_BUSY 0
`define RWWSP_CS_RWW_FLAG 1
`define RWWSP_CS_RWW_CLEAR 2
`define RWWSP_CS_STALL 3

// Lock register fields: two bits per section, one means unprogrammed
`define RWWSP_LOCK_APP_LO 0
`define RWWSP_LOCK_BOOT_LO 2
`define RWWSP_LOCK_RESET 4'hF

// Event bits
`define RWWSP_EV_DONE 0
`define RWWSP_EV_REJECT 1
`define RWWSP_EV_LOCKED 2
`define RWWSP_EV_W 3

// Store-program-memory operation codes
`define RWWSP_OP_FILL 2'h0
`define RWWSP_OP_ERASE 2'h1
`define RWWSP_OP_WRITE 2'h2
`define RWWSP_OP_RWW_ENABLE 2'h3

// Flash geometry defaults (bytes)
`define RWWSP_FLASH_BYTES 24'h040000
`define RWWSP_NO_READ_WHILE_WRITE_REGION_START 24'h03E000
`define RWWSP_BOOT_BASE_BYTES 24'h000400

// Timing
`define RWWSP_CLK_PERIOD_NS 4
`define RWWSP_PROG_TIME_NS 4500000
`define RWWSP_PROG_CYCLES ((`RWWSP_PROG_TIME_NS + `RWWSP_CLK_PERIOD_NS - 1) / `RWWSP_CLK_PERIOD_NS)

`endif

// ==== rwwsp_prog_timer.v ====
// Page erase/write duration timer
`timescale 1ns/1ps
module rwwsp_prog_timer #(
    parameter integer CYCLES = 1125000,
    parameter integer CNT_W = 24
) (
    input wire sys_clk_in,      // System clock
    input wire reset_n_in,      // Synchronous reset, active low
    input wire start_in,        // Start pulse
    output reg busy_out,        // Operation running
    output reg done_out         // One-cycle pulse at the end
);
    reg [CNT_W-1:0] count_reg;

    always @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            count_reg <= {CNT_W{1'b0}};
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in && !busy_out) begin
                count_reg <= CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
                busy_out <= 1'b1;
            end else if (busy_out) begin
                if (count_reg == {CNT_W{1'b0}}) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end else begin
                    count_reg <= count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// ==== rwwsp_sp_properties.sv ====
// Port-level checks of the self-programming control
`timescale 1ns/1ps
module rwwsp_sp_checker #(
    parameter integer PROG_CYCLES = 8,
    parameter [23:0] NO_READ_WHILE_WRITE_REGION_START = 24'h03E000
) (
    input wire sys_clk_in, // clock
    input wire reset_n_in, // reset
    input wire store_program_memory_op_in, // op pulse
    input wire [23:0] op_fetch_addr_in, // op fetch address
    input wire cpu_stall_out, // stall
    input wire rww_fetch_block_out, // fetch block
    input wire rww_region_busy_flag_out, // busy flag
    input wire [23:0] boot_start_out, // boot start
    input wire flash_prog_busy_out, // page op running
    input wire hreadyout_out, // bus ready
    input wire hresp_out // bus response
);
    reg [31:0] busy_cnt_reg;
    always @(posedge sys_clk_in) begin
        if (!reset_n_in || !flash_prog_busy_out)
            busy_cnt_reg <= 32'h0;
        else
            busy_cnt_reg <= busy_cnt_reg + 32'h1;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    property p_app_ignored;
        store_program_memory_op_in && op_fetch_addr_in < boot_start_out
            && !flash_prog_busy_out |=> !flash_prog_busy_out;
    endproperty
    a_app_ignored: assert property (p_app_ignored) else $error("app op started");
    property p_stall_in_op;
        cpu_stall_out |-> flash_prog_busy_out;
    endproperty
    a_stall_in_op: assert property (p_stall_in_op) else $error("stall without op");
    property p_stall_whole;
        flash_prog_busy_out && $past(flash_prog_busy_out) && $past(cpu_stall_out) |-> cpu_stall_out;
    endproperty
    a_stall_whole: assert property (p_stall_whole) else $error("stall dropped in op");
    property p_stall_start;
        $rose(cpu_stall_out) |-> $rose(flash_prog_busy_out);
    endproperty
    a_stall_start: assert property (p_stall_start) else $error("stall off op start");
    property p_rww_runs;
        flash_prog_busy_out && !cpu_stall_out |-> rww_region_busy_flag_out;
    endproperty
    a_rww_runs: assert property (p_rww_runs) else $error("flag low in rww op");
    property p_block_flag;
        rww_fetch_block_out == rww_region_busy_flag_out;
    endproperty
    a_block_flag: assert property (p_block_flag) else $error("block differs from flag");
    property p_flag_hold;
        $fell(flash_prog_busy_out) && $past(rww_region_busy_flag_out) |-> rww_region_busy_flag_out;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost at op end");
    property p_busy_len;
        $fell(flash_prog_busy_out) |-> busy_cnt_reg == PROG_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("op length wrong");
    property p_boot_no_read_while_write_region;
        boot_start_out >= NO_READ_WHILE_WRITE_REGION_START;
    endproperty
    a_boot_no_read_while_write_region: assert property (p_boot_no_read_while_write_region) else $error("boot start below boundary");
    property p_bus_okay;
        hreadyout_out && !hresp_out;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or error");
endmodule
bind rwwsp_self_program_control rwwsp_sp_checker #(.PROG_CYCLES(PROG_CYCLES),
    .NO_READ_WHILE_WRITE_REGION_START(NO_READ_WHILE_WRITE_REGION_START)) chk_u (.sys_clk_in, .reset_n_in, .store_program_memory_op_in,
    .op_fetch_addr_in, .cpu_stall_out, .rww_fetch_block_out, .rww_region_busy_flag_out,
    .boot_start_out, .flash_prog_busy_out, .hreadyout_out, .hresp_out);

// ==== rwwsp_cpu_model.sv ====
// Behavioural CPU core issuing store-program-memory ops
`timescale 1ns/1ps
module rwwsp_cpu_model #(
    parameter [23:0] NO_READ_WHILE_WRITE_REGION_START = 24'h03E000
) (
    input wire sys_clk_in, // clock
    input wire cpu_stall_in, // stall request
    input wire rww_fetch_block_in, // rww fetch block
    output reg op_out, // op pulse
    output reg [1:0] opcode_out, // op code
    output reg [23:0] fetch_addr_out, // op fetch address
    output reg [15:0] z_out // Z pointer
);
    // No interrupts are taken; vectors are meant to sit in the boot section
    initial begin
        op_out = 1'b0;
        opcode_out = 2'h0;
        fetch_addr_out = 24'h0;
        z_out = 16'h0;
    end
    task issue(input [1:0] op, input [23:0] fa, input [15:0] z, input integer pause);
        integer i;
        for (i = 0; i < pause; i = i + 1)
            @(posedge sys_clk_in);
        // A halted core, or code in a blocked region, cannot fetch the op
        while (cpu_stall_in || (rww_fetch_block_in && fa < NO_READ_WHILE_WRITE_REGION_START))
            @(posedge sys_clk_in);
        op_out <= 1'b1;
        opcode_out <= op;
        fetch_addr_out <= fa;
        z_out <= z;
        @(posedge sys_clk_in);
        // Stale operands are inverted so nothing leans on held values
        op_out <= 1'b0;
        opcode_out <= ~op;
        fetch_addr_out <= ~fa;
        z_out <= ~z;
    endtask
endmodule

// ==== rww_self_program_control_test.sv ====
// Self-checking testbench of the self-programming control
`timescale 1ns/1ps
`include "rwwsp_defs.vh"
module rww_self_program_control_test;
    reg sys_clk_in = 1'b0;
    reg reset_n_in = 1'b0;
    reg hsel_in = 1'b0;
    reg [31:0] haddr_in = 32'h0;
    reg [1:0] htrans_in = 2'h0;
    reg hwrite_in = 1'b0;
    reg [2:0] hsize_in = 3'h2;
    reg [31:0] hwdata_in = 32'h0;
    reg [1:0] boot_size_fuses_in = 2'h3;
    reg chip_erase_in = 1'b0;
    reg [3:0] lock_program_in = 4'hF;
    reg lock_program_we_in = 1'b0;
    wire [31:0] hrdata_out;
    wire hreadyout_out, hresp_out, store_program_memory_op_in, cpu_stall_out, irq_out;
    wire [1:0] op_code_in;
    wire [23:0] op_fetch_addr_in, boot_start_out;
    wire [15:0] z_pointer_in;
    wire rww_fetch_block_out, rww_region_busy_flag_out, flash_prog_busy_out;
    integer miscompares = 0;
    integer n_checks = 0;
    integer f;
    reg [31:0] q;
    rwwsp_self_program_control #(.PROG_CYCLES(8)) dut_u (.sys_clk_in, .reset_n_in, .hsel_in,
        .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in(hreadyout_out),
        .hrdata_out, .hreadyout_out, .hresp_out, .store_program_memory_op_in, .op_code_in,
        .op_fetch_addr_in, .z_pointer_in, .boot_size_fuses_in, .chip_erase_in,
        .lock_program_in, .lock_program_we_in, .cpu_stall_out, .rww_fetch_block_out,
        .rww_region_busy_flag_out, .boot_start_out, .flash_prog_busy_out, .irq_out);
    rwwsp_cpu_model cpu_u (.sys_clk_in, .cpu_stall_in(cpu_stall_out),
        .rww_fetch_block_in(rww_fetch_block_out), .op_out(store_program_memory_op_in),
        .opcode_out(op_code_in), .fetch_addr_out(op_fetch_addr_in), .z_out(z_pointer_in));
    initial forever #2 sys_clk_in = ~sys_clk_in;
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string name, input [31:0] seen, input [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task ahb(input w, input [7:0] a, input [31:0] d);
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        haddr_in <= {24'h0, a};
        hwrite_in <= w;
        @(posedge sys_clk_in);
        while (!hreadyout_out)
            @(posedge sys_clk_in);
        htrans_in <= 2'h0;
        hwdata_in <= d;
        @(posedge sys_clk_in);
        while (!hreadyout_out)
            @(posedge sys_clk_in);
        q = hrdata_out;
    endtask
    task wait_idle;
        integer i;
        @(posedge sys_clk_in);
        for (i = 0; i < 40 && flash_prog_busy_out; i = i + 1)
            @(posedge sys_clk_in);
        chk("busy end", flash_prog_busy_out, 32'h0);
    endtask
    task t_reset;
        chk("boot start", boot_start_out, 24'h03FC00);
        chk("flag", rww_region_busy_flag_out | cpu_stall_out | irq_out, 32'h0);
        ahb(1'b0, `RWWSP_OFS_LOCK, 32'h0);
        chk("lock", q, 32'hF);
        ahb(1'b1, 8'h20, 32'h5);
        ahb(1'b0, 8'h20, 32'h0);
        chk("unmapped", q, 32'h0);
    endtask
    task t_rww;
        ahb(1'b1, `RWWSP_OFS_IRQ_MASK, 32'h1);
        ahb(1'b1, `RWWSP_OFS_PAGE_HIGH, 32'h0);
        cpu_u.issue(`RWWSP_OP_ERASE, 24'h03FC10, 16'h1000, 0);
        @(posedge sys_clk_in);
        chk("busy", flash_prog_busy_out, 32'h1);
        chk("stall", cpu_stall_out, 32'h0);
        chk("flag", rww_region_busy_flag_out, 32'h1);
        chk("block", rww_fetch_block_out, 32'h1);
        wait_idle;
        chk("flag kept", rww_region_busy_flag_out, 32'h1);
        repeat (2) @(posedge sys_clk_in);
        chk("irq done", irq_out, 32'h1);
        ahb(1'b0, `RWWSP_OFS_IRQ_STATUS, 32'h0);
        chk("status", q, 32'h1);
        ahb(1'b1, `RWWSP_OFS_IRQ_STATUS, 32'h1);
        @(posedge sys_clk_in);
        chk("irq clear", irq_out, 32'h0);
        ahb(1'b1, `RWWSP_OFS_CTRL_STATUS, 32'h4);
        @(posedge sys_clk_in);
        chk("flag clear", rww_region_busy_flag_out, 32'h0);
        cpu_u.issue(`RWWSP_OP_WRITE, 24'h03FC20, 16'h2000, 3);
        wait_idle;
        cpu_u.issue(`RWWSP_OP_RWW_ENABLE, 24'h03FC30, 16'h0, 0);
        repeat (2) @(posedge sys_clk_in);
        chk("flag enable", rww_region_busy_flag_out, 32'h0);
        cpu_u.issue(`RWWSP_OP_FILL, 24'h03FC40, 16'h0, 0);
        @(posedge sys_clk_in);
        chk("fill", flash_prog_busy_out, 32'h0);
    endtask
    task t_no_read_while_write_region;
        ahb(1'b1, `RWWSP_OFS_PAGE_HIGH, 32'h3);
        cpu_u.issue(`RWWSP_OP_WRITE, 24'h03FC10, 16'hF000, 0);
        @(posedge sys_clk_in);
        chk("stall", cpu_stall_out, 32'h1);
        chk("flag", rww_region_busy_flag_out, 32'h0);
        wait_idle;
        chk("stall end", cpu_stall_out, 32'h0);
        cpu_u.issue(`RWWSP_OP_ERASE, 24'h03FD00, 16'hFE00, 0);
        @(posedge sys_clk_in);
        chk("boot self", flash_prog_busy_out & cpu_stall_out, 32'h1);
        wait_idle;
    endtask
    task t_reject;
        ahb(1'b1, `RWWSP_OFS_IRQ_STATUS, 32'h7);
        cpu_u.issue(`RWWSP_OP_ERASE, 24'h03E100, 16'h1000, 0);
        @(posedge sys_clk_in);
        chk("app op", flash_prog_busy_out, 32'h0);
        repeat (2) @(posedge sys_clk_in);
        chk("irq masked", irq_out, 32'h0);
        ahb(1'b0, `RWWSP_OFS_IRQ_STATUS, 32'h0);
        chk("reject", q, 32'h2);
        ahb(1'b1, `RWWSP_OFS_IRQ_MASK, 32'h2);
        @(posedge sys_clk_in);
        chk("irq reject", irq_out, 32'h1);
        ahb(1'b1, `RWWSP_OFS_IRQ_STATUS, 32'h2);
        @(posedge sys_clk_in);
        chk("irq off", irq_out, 32'h0);
    endtask
    task t_lock;
        ahb(1'b1, `RWWSP_OFS_LOCK, 32'hE);
        ahb(1'b1, `RWWSP_OFS_LOCK, 32'hF);
        ahb(1'b0, `RWWSP_OFS_LOCK, 32'h0);
        chk("lock set", q, 32'hE);
        cpu_u.issue(`RWWSP_OP_ERASE, 24'h03FC10, 16'hF000, 0);
        @(posedge sys_clk_in);
        chk("app locked", flash_prog_busy_out, 32'h0);
        ahb(1'b0, `RWWSP_OFS_IRQ_STATUS, 32'h0);
        chk("locked ev", q & 32'h4, 32'h4);
        cpu_u.issue(`RWWSP_OP_ERASE, 24'h03FC10, 16'hFE00, 0);
        @(posedge sys_clk_in);
        chk("boot open", flash_prog_busy_out, 32'h1);
        wait_idle;
        lock_program_in <= 4'hB;
        lock_program_we_in <= 1'b1;
        @(posedge sys_clk_in);
        lock_program_we_in <= 1'b0;
        ahb(1'b0, `RWWSP_OFS_LOCK, 32'h0);
        chk("lock prog", q, 32'hA);
        chk_erase_pulse;
        ahb(1'b0, `RWWSP_OFS_LOCK, 32'h0);
        chk("chip erase", q, 32'hF);
    endtask
    task chk_erase_pulse;
        chip_erase_in <= 1'b1;
        @(posedge sys_clk_in);
        chip_erase_in <= 1'b0;
    endtask
    task t_fuses;
        for (f = 0; f < 4; f = f + 1) begin
            boot_size_fuses_in <= f[1:0];
            repeat (4) @(posedge sys_clk_in);
            chk("boot size", boot_start_out, (f == 0) ? 24'h03E000 : (f == 1) ? 24'h03F000 :
                (f == 2) ? 24'h03F800 : 24'h03FC00);
        end
    endtask
    initial begin
        repeat (3) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        t_reset;
        t_rww;
        t_no_read_while_write_region;
        t_reject;
        t_lock;
        t_fuses;
        end_sim;
    end
    initial begin
        #40000;
        miscompares = miscompares + 1;
        end_sim;
    end
endmodule
